// ===== pkg/sfepi_pkg.sv
// Purpose: shared constants for the serial flash erase, sleep and id block
// Assumes: 40 MHz system clock on both ends
// Notes: delay figures are plain defaults, adjust per part
package sfepi_pkg;
  // Command opcodes
  localparam logic [7:0] OP_WEN = 8'h06;
  localparam logic [7:0] OP_ERASE_A = 8'h60;
  localparam logic [7:0] OP_ERASE_B = 8'hc7;
  localparam logic [7:0] OP_DEEP = 8'hb9;
  localparam logic [7:0] OP_REL = 8'hab;
  localparam logic [7:0] OP_ID = 8'h90;
  localparam logic [7:0] OP_ID_DUAL = 8'h92;

  // Identification bytes, values arbitrary
  localparam logic [7:0] MAKER_ID = 8'h5a;
  localparam logic [7:0] DEVICE_ID = 8'h3c;

  // Bit counts of a frame, opcode included
  localparam logic [5:0] OPC_BITS = 6'h08;
  localparam logic [5:0] ADR_END_SINGLE = 6'h20;
  localparam logic [5:0] ADR_END_DUAL = 6'h14;

  // Timing, in their own units, and derived cycle counts
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned T_SLP_NS = 3000;
  localparam int unsigned T_RES1_NS = 3000;
  localparam int unsigned T_RES2_NS = 1800;
  localparam int unsigned T_ERASE_US = 1000;
  localparam logic [15:0] SLP_CYC = 16'((T_SLP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] RES1_CYC = 16'((T_RES1_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] RES2_CYC = 16'((T_RES2_NS * CLK_MHZ + 999) / 1000);
  localparam int unsigned ERASE_CYC = T_ERASE_US * CLK_MHZ;

  // Host link timing: half serial clock period, sync lag margin
  localparam logic [3:0] SCLK_HALF = 4'h8;
  localparam logic [15:0] SYNC_LAG = 16'h0004;
  localparam logic [15:0] CS_GAP_CYC = ((RES1_CYC > RES2_CYC) ? RES1_CYC : RES2_CYC) + SYNC_LAG;

  // Host register map, byte offsets
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_ADDR = 5'h04;
  localparam logic [4:0] REG_STAT = 5'h08;
  localparam logic [4:0] REG_RXD = 5'h0c;
  localparam int CTRL_GO_BIT = 8;
  localparam int CTRL_AEN_BIT = 9;
  localparam int CTRL_DUAL_BIT = 10;
  localparam int CTRL_RD_LSB = 12;
  localparam int STAT_BUSY_BIT = 0;
endpackage

// ===== pkg/sfepi_link_if.sv
// Purpose: serial flash link between host controller and device
// Assumes: io lines pulled up when nobody drives
// Notes: device drive wins on contention, bench should flag it
`timescale 1ns/1ps
interface sfepi_link_if;
  logic cs_n;
  logic sclk;
  logic [1:0] h_io_o;
  logic [1:0] h_io_oe;
  logic [1:0] d_io_o;
  logic [1:0] d_io_oe;
  logic [1:0] io;

  // Resolved line level from both enables
  assign io = (d_io_oe & d_io_o) | (~d_io_oe & h_io_oe & h_io_o) | (~d_io_oe & ~h_io_oe);

  modport dev (input cs_n, input sclk, input io, output d_io_o, output d_io_oe);
  modport host (output cs_n, output sclk, output h_io_o, output h_io_oe, input io);
endinterface

// ===== rtl/sfepi_dev.sv
// Purpose: serial flash command decoder, device end
// Assumes: link pins asynchronous to CLK_I, sclk well below CLK_I/6
// Notes: write enable, erase, deep sleep, release and identification commands only
// Functional notes
// R01: whole erase needs write enable latch set
// R02: erase dropped unless deselect after bit eight
// R03: erase start sets busy until finished
// R04: erase clears write enable latch early
// R05: erase ignored when any block protected
// R06: sleep opcode enters deep sleep after delay
// R07: deep sleep ignores all but release opcode
// R08: sleep needs deselect exactly after bit eight
// R09: sleep rejected while a cycle runs
// R10: plain deselect gives standby, not sleep
// R11: reset always restarts in standby
// R12: release only: no command during first delay
// R13: release with dummies shifts device id out
// R14: device id repeats until deselect
// R15: id read from sleep waits second delay
// R16: release and id ignored while busy; code gates release only, OP_ID and OP_ID_DUAL still run while busy
// R17: id command gives maker then device byte
// R18: address one swaps id byte order
// R19: dual id uses two lines both ways
// R20: bits sampled on rising sclk, msb first
//
// Chosen here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module sfepi_dev #(
  parameter int unsigned ERASE_CYC = sfepi_pkg::ERASE_CYC // Erase length in cycles
) (
  input wire logic CLK_I, // System clock, 40 MHz
  input wire logic RST_N_I, // Synchronous reset, active low
  sfepi_link_if.dev LINK, // Serial flash pins
  input wire logic [4:0] BLOCK_PROTECT_I, // Block protect bits 4..0
  input wire logic EXT_BUSY_I, // Other program or write cycle running
  output logic WRITE_IN_PROGRESS_O, // Busy flag
  output logic WRITE_ENABLE_LATCH_O, // Write enable latch
  output logic DEEP_SLEEP_O, // Deep sleep mode reached
  output logic ERASE_START_O // One pulse when an erase starts
);
  typedef enum logic [2:0] {ST_IDLE, ST_OPC, ST_ADDR, ST_OUT, ST_SKIP} sfepi_dst_t;
  typedef enum logic [1:0] {PW_NORM, PW_ENTER, PW_DEEP, PW_WAKE} sfepi_pwr_t;

  logic [1:0] sclk_s;
  logic [1:0] cs_s;
  logic [1:0] io0_s;
  logic [1:0] io1_s;
  logic sclk_d;
  logic cs_d;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  logic sel;
  sfepi_dst_t st;
  sfepi_pwr_t pw;
  logic [7:0] op;
  logic [23:0] adr;
  logic [5:0] nbits;
  logic dual;
  logic [15:0] sh;
  logic [1:0] d_o;
  logic [1:0] d_oe;
  logic wlatch;
  logic erasing;
  logic erase_pulse;
  logic [31:0] ecnt;
  logic [15:0] pcnt;
  logic busy;
  logic [7:0] next_op;
  logic [23:0] next_adr;
  logic [5:0] adr_end;
  logic wen_go;
  logic erase_go;
  logic slp_go;
  logic rel1_go;
  logic rel2_go;

  // Two-flop synchronisers on every pin, first stage read by second only
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      sclk_s <= 2'h0;
      cs_s <= 2'h3;
      io0_s <= 2'h3;
      io1_s <= 2'h3;
      sclk_d <= 1'b0;
      cs_d <= 1'b1;
    end else begin
      sclk_s <= {sclk_s[0], LINK.sclk};
      cs_s <= {cs_s[0], LINK.cs_n};
      io0_s <= {io0_s[0], LINK.io[0]};
      io1_s <= {io1_s[0], LINK.io[1]};
      sclk_d <= sclk_s[1];
      cs_d <= cs_s[1];
    end
  end

  // Edge detect on the synchronised levels only
  assign sclk_rise = sclk_s[1] & ~sclk_d;
  assign sclk_fall = ~sclk_s[1] & sclk_d;
  assign cs_rise = cs_s[1] & ~cs_d;
  assign sel = ~cs_s[1];

  // Shift-in values, io1 carries the higher bit in dual mode
  assign next_op = {op[6:0], io0_s[1]}; // [R20]
  assign next_adr = dual ? {adr[21:0], io1_s[1], io0_s[1]} : {adr[22:0], io0_s[1]}; // [R19]
  assign adr_end = dual ? sfepi_pkg::ADR_END_DUAL : sfepi_pkg::ADR_END_SINGLE;
  assign busy = erasing | EXT_BUSY_I;

  // Commands are judged only at the deselect edge, on exact bit count, release-id on reaching id output
  always_comb begin
    wen_go = cs_rise && nbits == sfepi_pkg::OPC_BITS && op == sfepi_pkg::OP_WEN &&
             pw == PW_NORM && !busy;
    erase_go = cs_rise && nbits == sfepi_pkg::OPC_BITS && // [R02]
               (op == sfepi_pkg::OP_ERASE_A || op == sfepi_pkg::OP_ERASE_B) &&
               pw == PW_NORM && !busy && wlatch && // [R01]
               BLOCK_PROTECT_I == 5'h00; // [R05]
    slp_go = cs_rise && nbits == sfepi_pkg::OPC_BITS && // [R08]
             op == sfepi_pkg::OP_DEEP && pw == PW_NORM && !busy; // [R09]
    rel1_go = cs_rise && nbits == sfepi_pkg::OPC_BITS && op == sfepi_pkg::OP_REL &&
              pw == PW_DEEP && !busy; // [R16]
    rel2_go = cs_rise && st == ST_OUT && op == sfepi_pkg::OP_REL && pw == PW_DEEP;
  end

  // Frame sequencer: opcode, address or dummies, then id output
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      st <= ST_IDLE;
      nbits <= 6'h00;
      op <= 8'h00;
      adr <= 24'h000000;
      dual <= 1'b0;
      sh <= 16'h0000;
    end else if (!sel) begin
      // Deselect ends any frame, including an endless id read
      st <= ST_IDLE; // [R14]
      nbits <= 6'h00;
    end else if (sclk_rise) begin
      // Saturate so long frames never alias to a short count
      if (nbits != 6'h3f) begin
        nbits <= nbits + 6'h01;
      end
      case (st)
        ST_IDLE, ST_OPC: begin
          op <= next_op; // [R20]
          st <= ST_OPC;
          if (nbits == sfepi_pkg::OPC_BITS - 6'h01) begin
            if (pw == PW_DEEP && next_op != sfepi_pkg::OP_REL) begin
              st <= ST_SKIP; // [R07]
            end else if (pw == PW_ENTER || pw == PW_WAKE) begin
              st <= ST_SKIP; // [R12] [R15]
            end else if (next_op == sfepi_pkg::OP_REL) begin
              st <= busy ? ST_SKIP : ST_ADDR; // [R16]
              dual <= 1'b0;
            end else if (next_op == sfepi_pkg::OP_ID && pw == PW_NORM) begin
              st <= ST_ADDR; // [R17]
              dual <= 1'b0;
            end else if (next_op == sfepi_pkg::OP_ID_DUAL && pw == PW_NORM) begin
              st <= ST_ADDR; // [R19]
              dual <= 1'b1;
            end else begin
              st <= ST_SKIP;
            end
          end
        end
        ST_ADDR: begin
          adr <= next_adr;
          if (nbits == adr_end - 6'h01) begin
            st <= ST_OUT;
            if (op == sfepi_pkg::OP_REL) begin
              sh <= {sfepi_pkg::DEVICE_ID, sfepi_pkg::DEVICE_ID}; // [R13]
            end else if (next_adr[0]) begin
              sh <= {sfepi_pkg::DEVICE_ID, sfepi_pkg::MAKER_ID}; // [R18]
            end else begin
              sh <= {sfepi_pkg::MAKER_ID, sfepi_pkg::DEVICE_ID}; // [R17]
            end
          end
        end
        default: ;
      endcase
    end else if (sclk_fall && st == ST_OUT) begin
      // Rotate so the bytes repeat for as long as the clock runs
      sh <= dual ? {sh[13:0], sh[15:14]} : {sh[14:0], sh[15]}; // [R14]
    end
  end

  // Output pins change on falling sclk, msb first; released on deselect
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      d_o <= 2'h0;
      d_oe <= 2'h0;
    end else if (!sel || st != ST_OUT) begin
      d_oe <= 2'h0;
    end else if (sclk_fall) begin
      d_o <= dual ? sh[15:14] : {sh[15], 1'b0}; // [R13] [R19]
      d_oe <= dual ? 2'h3 : 2'h2;
    end
  end

  // Power mode; reset is the power-up path, always standby
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      pw <= PW_NORM; // [R11]
      pcnt <= 16'h0000;
    end else begin
      case (pw)
        PW_NORM: begin
          // A plain deselect never reaches here without the sleep opcode
          if (slp_go) begin
            pw <= PW_ENTER; // [R06] [R10]
            pcnt <= sfepi_pkg::SLP_CYC - 16'h0001;
          end
        end
        PW_ENTER: begin
          if (pcnt == 16'h0000) begin
            pw <= PW_DEEP; // [R06]
          end else begin
            pcnt <= pcnt - 16'h0001;
          end
        end
        PW_DEEP: begin
          if (rel1_go) begin
            pw <= PW_WAKE; // [R12]
            pcnt <= sfepi_pkg::RES1_CYC - 16'h0001;
          end else if (rel2_go) begin
            pw <= PW_WAKE; // [R15]
            pcnt <= sfepi_pkg::RES2_CYC - 16'h0001;
          end
        end
        PW_WAKE: begin
          if (pcnt == 16'h0000) begin
            pw <= PW_NORM;
          end else begin
            pcnt <= pcnt - 16'h0001;
          end
        end
        default: pw <= PW_NORM;
      endcase
    end
  end

  // Self-timed erase; busy held for the whole count
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      erasing <= 1'b0;
      erase_pulse <= 1'b0;
      ecnt <= 32'h00000000;
    end else begin
      erase_pulse <= erase_go;
      if (erase_go) begin
        erasing <= 1'b1; // [R03]
        ecnt <= 32'(ERASE_CYC - 1);
      end else if (erasing) begin
        if (ecnt == 32'h00000000) begin
          erasing <= 1'b0; // [R03]
        end else begin
          ecnt <= ecnt - 32'h00000001;
        end
      end
    end
  end

  // Write enable latch; cleared as the erase starts, well before its end
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      wlatch <= 1'b0;
    end else if (erase_go) begin
      wlatch <= 1'b0; // [R04]
    end else if (wen_go) begin
      wlatch <= 1'b1;
    end
  end

  // Status and pin outputs
  assign WRITE_IN_PROGRESS_O = busy;
  assign WRITE_ENABLE_LATCH_O = wlatch;
  assign DEEP_SLEEP_O = (pw == PW_DEEP);
  assign ERASE_START_O = erase_pulse;
  assign LINK.d_io_o = d_o;
  assign LINK.d_io_oe = d_oe;
endmodule // sfepi_dev

// ===== rtl/sfepi_host.sv
// Purpose: host controller for the serial flash link, AHB-Lite slave
// Assumes: zero-wait single word accesses, response always OKAY
// Notes: software sets opcode, address and read length, then go
`timescale 1ns/1ps
module sfepi_host (
  input wire logic CLK_I, // System clock, 40 MHz
  input wire logic RST_N_I, // Synchronous reset, active low
  input wire logic HSEL_I, // Slave select
  input wire logic [31:0] HADDR_I, // Byte address
  input wire logic [1:0] HTRANS_I, // Transfer type
  input wire logic HWRITE_I, // Write when high
  input wire logic [2:0] HSIZE_I, // Word only, not checked
  input wire logic [31:0] HWDATA_I, // Write data
  input wire logic HREADY_I, // Bus ready
  output logic [31:0] HRDATA_O, // Read data
  output logic HREADYOUT_O, // Always ready
  output logic HRESP_O, // Always OKAY
  sfepi_link_if.host LINK // Serial flash pins
);
  typedef enum logic [1:0] {HS_IDLE, HS_TX, HS_RX, HS_GAP} sfepi_hst_t;

  sfepi_hst_t st;
  logic [7:0] op;
  logic aen;
  logic dual;
  logic [3:0] rdn;
  logic [23:0] addr;
  logic [31:0] rx;
  logic go_q;
  logic busy;
  logic [3:0] div;
  logic tick;
  logic sclk;
  logic cs_n;
  logic [1:0] io_o;
  logic [1:0] io_oe;
  logic [31:0] tx;
  logic [31:0] next_tx;
  logic next_two;
  logic [5:0] edges;
  logic [5:0] ntx;
  logic [6:0] rdleft;
  logic [15:0] gap;
  logic [1:0] io0_s;
  logic [1:0] io1_s;
  logic dph_wr;
  logic [4:0] dph_a;
  logic [31:0] hrdata;
  logic [31:0] rd_val;
  logic addr_ph;

  assign busy = (st != HS_IDLE) || go_q;
  assign tick = (div == sfepi_pkg::SCLK_HALF - 4'h1);
  assign addr_ph = HREADY_I & HSEL_I & HTRANS_I[1];

  // Read mux, sampled in the address phase so data comes from a flop
  always_comb begin
    case (HADDR_I[4:0])
      sfepi_pkg::REG_CTRL: rd_val = {16'h0000, rdn, 1'b0, dual, aen, 1'b0, op};
      sfepi_pkg::REG_ADDR: rd_val = {8'h00, addr};
      sfepi_pkg::REG_STAT: rd_val = {31'h00000000, busy};
      sfepi_pkg::REG_RXD: rd_val = rx;
      default: rd_val = 32'h00000000;
    endcase
  end

  // Bus slave: address phase capture, zero wait states
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      dph_wr <= 1'b0;
      dph_a <= 5'h00;
      hrdata <= 32'h00000000;
    end else begin
      dph_wr <= addr_ph & HWRITE_I;
      dph_a <= HADDR_I[4:0];
      if (addr_ph && !HWRITE_I) begin
        hrdata <= rd_val;
      end
    end
  end

  // Register writes; settings frozen while a frame runs
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      op <= 8'h00;
      aen <= 1'b0;
      dual <= 1'b0;
      rdn <= 4'h0;
      addr <= 24'h000000;
      go_q <= 1'b0;
    end else begin
      go_q <= 1'b0;
      if (dph_wr && !busy) begin
        if (dph_a == sfepi_pkg::REG_CTRL) begin
          op <= HWDATA_I[7:0];
          aen <= HWDATA_I[sfepi_pkg::CTRL_AEN_BIT];
          dual <= HWDATA_I[sfepi_pkg::CTRL_DUAL_BIT];
          rdn <= HWDATA_I[sfepi_pkg::CTRL_RD_LSB +: 4];
          go_q <= HWDATA_I[sfepi_pkg::CTRL_GO_BIT];
        end else if (dph_a == sfepi_pkg::REG_ADDR) begin
          addr <= HWDATA_I[23:0];
        end
      end
    end
  end

  // Incoming lines synchronised before sampling
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      io0_s <= 2'h3;
      io1_s <= 2'h3;
    end else begin
      io0_s <= {io0_s[0], LINK.io[0]};
      io1_s <= {io1_s[0], LINK.io[1]};
    end
  end

  // Serial clock divider; the half period leaves room for both syncs
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I || st == HS_IDLE || tick) begin
      div <= 4'h0;
    end else begin
      div <= div + 4'h1;
    end
  end

  // Next transmit word; address bits go two at a time in dual mode
  assign next_two = dual && (edges + 6'h01) >= sfepi_pkg::OPC_BITS;
  assign next_tx = (dual && edges >= sfepi_pkg::OPC_BITS) ? {tx[29:0], 2'h0} : {tx[30:0], 1'b0};

  // Frame sequencer: data changes on falling sclk, read sampled on rising
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      st <= HS_IDLE;
      sclk <= 1'b0;
      cs_n <= 1'b1;
      io_o <= 2'h0;
      io_oe <= 2'h0;
      tx <= 32'h00000000;
      edges <= 6'h00;
      ntx <= 6'h00;
      rdleft <= 7'h00;
      gap <= 16'h0000;
      rx <= 32'h00000000;
    end else begin
      case (st)
        HS_IDLE: begin
          if (go_q) begin
            cs_n <= 1'b0;
            tx <= {op, addr};
            io_o <= {1'b0, op[7]}; // [R20]
            io_oe <= 2'h1;
            edges <= 6'h00;
            ntx <= aen ? (dual ? sfepi_pkg::ADR_END_DUAL : sfepi_pkg::ADR_END_SINGLE) :
                   sfepi_pkg::OPC_BITS;
            rdleft <= dual ? {1'b0, rdn, 2'h0} : {rdn, 3'h0}; // [R19]
            rx <= 32'h00000000;
            st <= HS_TX;
          end
        end
        HS_TX: begin
          if (tick && !sclk) begin
            sclk <= 1'b1;
          end else if (tick) begin
            sclk <= 1'b0;
            edges <= edges + 6'h01;
            if (edges + 6'h01 == ntx) begin
              io_oe <= 2'h0;
              if (rdleft != 7'h00) begin
                st <= HS_RX;
              end else begin
                cs_n <= 1'b1; // [R02] [R08]
                gap <= sfepi_pkg::CS_GAP_CYC;
                st <= HS_GAP;
              end
            end else begin
              tx <= next_tx;
              io_o <= next_two ? next_tx[31:30] : {1'b0, next_tx[31]}; // [R19]
              io_oe <= next_two ? 2'h3 : 2'h1;
            end
          end
        end
        HS_RX: begin
          if (tick && !sclk) begin
            sclk <= 1'b1;
            rx <= dual ? {rx[29:0], io1_s[1], io0_s[1]} : {rx[30:0], io1_s[1]}; // [R17]
          end else if (tick) begin
            sclk <= 1'b0;
            rdleft <= rdleft - 7'h01;
            if (rdleft == 7'h01) begin
              cs_n <= 1'b1;
              gap <= sfepi_pkg::CS_GAP_CYC;
              st <= HS_GAP;
            end
          end
        end
        HS_GAP: begin
          // Chip select held high long enough for either release delay
          if (gap == 16'h0000) begin
            st <= HS_IDLE; // [R12] [R15]
          end else begin
            gap <= gap - 16'h0001;
          end
        end
        default: st <= HS_IDLE;
      endcase
    end
  end

  assign HRDATA_O = hrdata;
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;
  assign LINK.cs_n = cs_n;
  assign LINK.sclk = sclk;
  assign LINK.h_io_o = io_o;
  assign LINK.h_io_oe = io_oe;
endmodule // sfepi_host

// ===== dv/sfepi_props.sv
// Purpose: concurrent checks on the flash link and device status pins
// Assumes: one clock domain, synchronous active low reset
// Notes: link pins lag the clock by a few cycles of synchroniser delay
`timescale 1ns/1ps
module sfepi_props #(
  parameter int unsigned ERASE_CYC = 200 // Erase length in cycles
) (
  input wire logic CLK_I, // System clock
  input wire logic RST_N_I, // Reset, active low
  input wire logic cs_n, // Chip select
  input wire logic sclk, // Serial clock
  input wire logic [1:0] h_io_oe, // Host drive enables
  input wire logic [1:0] d_io_oe, // Device drive enables
  input wire logic [4:0] BLOCK_PROTECT_I, // Protect bits
  input wire logic EXT_BUSY_I, // Other cycle running
  input wire logic WRITE_IN_PROGRESS_O, // Busy flag
  input wire logic WRITE_ENABLE_LATCH_O, // Write enable latch
  input wire logic DEEP_SLEEP_O, // Deep sleep reached
  input wire logic ERASE_START_O // Erase start pulse
);
  // Slack for the end of erase, covers sync lag
  localparam int E_HI = ERASE_CYC + 10;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  // Erase gates: latch, protection, framing
  erase_lat_a: assert property (ERASE_START_O |-> $past(WRITE_ENABLE_LATCH_O, 3))
    else $error("erase started without write enable");
  erase_frame_a: assert property (ERASE_START_O |-> $past(cs_n, 1) && $past(cs_n, 2))
    else $error("erase started while selected");
  erase_busy_a: assert property (ERASE_START_O |-> WRITE_IN_PROGRESS_O [*8])
    else $error("busy not held after erase start");
  erase_end_a: assert property (ERASE_START_O && !EXT_BUSY_I |-> ##[1:E_HI] !WRITE_IN_PROGRESS_O)
    else $error("erase busy never cleared");
  lat_clear_a: assert property (ERASE_START_O |-> ##[0:2] !WRITE_ENABLE_LATCH_O)
    else $error("write enable not cleared by erase");
  erase_prot_a: assert property (ERASE_START_O |-> $past(BLOCK_PROTECT_I, 4) == 5'h00)
    else $error("erase started while protected");
  // Deep entry only after a quiet deselected stretch
  sleep_delay_a: assert property ($rose(DEEP_SLEEP_O) |-> $past(cs_n, 100))
    else $error("deep sleep entered too early");
  sleep_deaf_a: assert property (DEEP_SLEEP_O |-> !ERASE_START_O)
    else $error("erase accepted in deep sleep");
  out_release_a: assert property ($rose(cs_n) |-> ##[0:5] (d_io_oe == 2'h0))
    else $error("device still drives after deselect");
  no_clash_a: assert property ((d_io_oe & h_io_oe) == 2'h0)
    else $error("both ends drive one line");
  sclk_idle_a: assert property (cs_n && $past(cs_n) |-> !sclk)
    else $error("serial clock runs while deselected");

  // Main scenarios reached
  cover property (ERASE_START_O);
  cover property ($rose(DEEP_SLEEP_O));
  cover property (d_io_oe == 2'h3);
endmodule // sfepi_props

// ===== dv/tb_sfepi.sv
// Purpose: host and device ends of the flash link run against each other
// Assumes: host keeps its own deselect gap and raises busy per frame
// Notes: read data come back through the host receive register
`timescale 1ns/1ps
module tb_sfepi;
  localparam int unsigned ECYC = 200;
  logic clk, rst_n, hsel, hwrite, ext_busy, hreadyout, hresp, bsy, lat, deep, estart;
  logic prev_sclk, prev_cs;
  logic [31:0] haddr, hwdata, hrdata, rx;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [4:0] bp;
  int mismatches, total_checks, cycles, erase_cnt, edges, last_edges, i, n;
  logic [7:0] ops [2] = '{sfepi_pkg::OP_ERASE_A, sfepi_pkg::OP_ERASE_B};

  sfepi_link_if link();
  sfepi_host i_sfepi_host (.CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
    .HREADY_I(hreadyout), .HRDATA_O(hrdata), .HREADYOUT_O(hreadyout), .HRESP_O(hresp),
    .LINK(link));
  sfepi_dev #(.ERASE_CYC(ECYC)) i_sfepi_dev (.CLK_I(clk), .RST_N_I(rst_n), .LINK(link),
    .BLOCK_PROTECT_I(bp), .EXT_BUSY_I(ext_busy), .WRITE_IN_PROGRESS_O(bsy),
    .WRITE_ENABLE_LATCH_O(lat), .DEEP_SLEEP_O(deep), .ERASE_START_O(estart));
  sfepi_props #(.ERASE_CYC(ECYC)) i_sfepi_props (.CLK_I(clk), .RST_N_I(rst_n),
    .cs_n(link.cs_n), .sclk(link.sclk), .h_io_oe(link.h_io_oe), .d_io_oe(link.d_io_oe),
    .BLOCK_PROTECT_I(bp), .EXT_BUSY_I(ext_busy), .WRITE_IN_PROGRESS_O(bsy),
    .WRITE_ENABLE_LATCH_O(lat), .DEEP_SLEEP_O(deep), .ERASE_START_O(estart));

  // Clock, 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Timeout, erase pulses, sclk rises per frame
  always @(posedge clk) begin
    cycles++;
    if (estart === 1'b1) erase_cnt++;
    if (link.cs_n === 1'b1 && prev_cs === 1'b0) last_edges = edges;
    if (link.cs_n === 1'b1) edges = 0;
    else if (link.sclk === 1'b1 && prev_sclk === 1'b0) edges++;
    prev_sclk = link.sclk;
    prev_cs = link.cs_n;
    if (cycles == 60000) begin
      mismatches++;
      results();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Single word transfer; address held until ready, data phase until ready
  task automatic ahb(input logic w, input logic [4:0] off, input logic [31:0] d,
                     output logic [31:0] r);
    htrans <= 2'h2;
    haddr <= {27'h0, off};
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    r = hrdata;
  endtask

  // One frame: address, control with go, poll busy, fetch received bits
  task automatic cmd(input logic [7:0] op, input logic aen, input logic dual,
                     input logic [3:0] rd, input logic [23:0] a);
    logic [31:0] r;
    ahb(1'b1, sfepi_pkg::REG_ADDR, {8'h00, a}, r);
    ahb(1'b1, sfepi_pkg::REG_CTRL, {16'h0, rd, 1'b0, dual, aen, 1'b1, op}, r);
    r = 32'h1;
    while (r[0] !== 1'b0) ahb(1'b0, sfepi_pkg::REG_STAT, 32'h0, r);
    ahb(1'b0, sfepi_pkg::REG_RXD, 32'h0, rx);
  endtask

  // Bounded wait for the sleep flag, then compare
  task automatic wait_deep(input logic v);
    for (int k = 0; k < 300 && deep !== v; k++) @(posedge clk);
    chk({31'h0, deep}, {31'h0, v});
  endtask

  // Four id bytes as received, newest in the low byte
  function automatic logic [31:0] exp_id(input logic [7:0] op, input logic a0);
    logic [31:0] v;
    v = 32'h0;
    for (int k = 0; k < 4; k++) begin
      if (op == sfepi_pkg::OP_REL || (k[0] ^ a0)) v = {v[23:0], sfepi_pkg::DEVICE_ID};
      else v = {v[23:0], sfepi_pkg::MAKER_ID};
    end
    return v;
  endfunction

  // Main sequence
  initial begin
    {hsel, hwrite, ext_busy, prev_sclk, prev_cs} = 5'h11;
    {haddr, hwdata, htrans, bp} = '0;
    hsize = 3'h2;
    rst_n = 1'b0;
    void'($urandom(32'h0ee3));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    cmd(sfepi_pkg::OP_ERASE_A, 1'b0, 1'b0, 4'h0, 24'h0);
    chk(erase_cnt, 0);
    cmd(sfepi_pkg::OP_WEN, 1'b0, 1'b0, 4'h0, 24'h0);
    chk({31'h0, lat}, 32'h1);
    bp <= 5'($urandom_range(31, 1));
    cmd(sfepi_pkg::OP_ERASE_B, 1'b0, 1'b0, 4'h0, 24'h0);
    chk(erase_cnt, 0);
    bp <= 5'h00;
    cmd(sfepi_pkg::OP_ERASE_A, 1'b1, 1'b0, 4'h0, 24'($urandom));
    chk(erase_cnt, 0);
    $display("test erase refusals done");
    // Both erase opcodes, start pulse follows deselect by a few cycles
    for (i = 0; i < 2; i++) begin
      cmd(sfepi_pkg::OP_WEN, 1'b0, 1'b0, 4'h0, 24'h0);
      n = erase_cnt;
      cmd(ops[i], 1'b0, 1'b0, 4'h0, 24'h0);
      repeat (8) @(posedge clk);
      chk(erase_cnt, n + 1);
      chk(last_edges, 8);
      chk({31'h0, bsy}, 32'h1);
      chk({31'h0, lat}, 32'h0);
      for (n = 0; n < 300 && bsy !== 1'b0; n++) @(posedge clk);
      chk({31'h0, bsy}, 32'h0);
    end
    $display("test erase done");
    // Id reads on one and two lines, both address orders
    for (i = 0; i < 4; i++) begin
      cmd(i[1] ? sfepi_pkg::OP_ID_DUAL : sfepi_pkg::OP_ID, 1'b1, i[1], 4'h4, {23'h0, i[0]});
      chk(rx, exp_id(sfepi_pkg::OP_ID, i[0]));
    end
    cmd(sfepi_pkg::OP_REL, 1'b1, 1'b0, 4'h4, 24'($urandom));
    chk(rx, exp_id(sfepi_pkg::OP_REL, 1'b0));
    wait_deep(1'b0);
    $display("test id done");
    // Another cycle running: release-id and sleep both refused
    ext_busy <= 1'b1;
    cmd(sfepi_pkg::OP_REL, 1'b1, 1'b0, 4'h4, 24'($urandom));
    chk(rx, 32'hffffffff);
    cmd(sfepi_pkg::OP_DEEP, 1'b0, 1'b0, 4'h0, 24'h0);
    wait_deep(1'b0);
    ext_busy <= 1'b0;
    $display("test busy refusals done");
    // Deep sleep entry, deafness and both release forms
    cmd(sfepi_pkg::OP_DEEP, 1'b1, 1'b0, 4'h0, 24'($urandom));
    wait_deep(1'b0);
    cmd(sfepi_pkg::OP_DEEP, 1'b0, 1'b0, 4'h0, 24'h0);
    wait_deep(1'b1);
    n = erase_cnt;
    cmd(sfepi_pkg::OP_WEN, 1'b0, 1'b0, 4'h0, 24'h0);
    cmd(sfepi_pkg::OP_ERASE_B, 1'b0, 1'b0, 4'h0, 24'h0);
    chk(erase_cnt, n);
    cmd(sfepi_pkg::OP_ID, 1'b1, 1'b0, 4'h4, 24'h0);
    chk(rx, 32'hffffffff);
    cmd(sfepi_pkg::OP_REL, 1'b0, 1'b0, 4'h0, 24'h0);
    wait_deep(1'b0);
    cmd(sfepi_pkg::OP_ID, 1'b1, 1'b0, 4'h4, 24'h0);
    chk(rx, exp_id(sfepi_pkg::OP_ID, 1'b0));
    cmd(sfepi_pkg::OP_DEEP, 1'b0, 1'b0, 4'h0, 24'h0);
    wait_deep(1'b1);
    cmd(sfepi_pkg::OP_REL, 1'b1, 1'b0, 4'h4, 24'($urandom));
    wait_deep(1'b0);
    cmd(sfepi_pkg::OP_ID, 1'b1, 1'b0, 4'h4, 24'h1);
    chk(rx, exp_id(sfepi_pkg::OP_ID, 1'b1));
    $display("test deep sleep done");
    // Reset in deep sleep comes back in standby
    cmd(sfepi_pkg::OP_DEEP, 1'b0, 1'b0, 4'h0, 24'h0);
    wait_deep(1'b1);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({31'h0, deep}, 32'h0);
    repeat (3) @(posedge clk);
    cmd(sfepi_pkg::OP_ID, 1'b1, 1'b0, 4'h4, 24'h0);
    chk(rx, exp_id(sfepi_pkg::OP_ID, 1'b0));
    $display("test reset done");
    results();
  end
endmodule // tb_sfepi
